// >>> verilog/prl_pkg.sv
// Constants and types of the port ingress rate limiter.
// Assumes a 20 MHz core clock and byte-wide registers at their port offsets.
package prl_pkg;

    // ==========================================================
    // Register offsets within one port.
    localparam logic [11:0] OFS_CTRL   = 12'h403;
    localparam logic [11:0] OFS_PRIO0  = 12'h410;
    localparam logic [11:0] OFS_PRIO7  = 12'h417;
    localparam logic [11:0] OFS_STATUS = 12'h418;

    // ==========================================================
    // Control register fields and reset values.
    localparam int         CTL_PORT_BIT = 6;
    localparam int         CTL_PKT_BIT  = 5;
    localparam int         CTL_FC_BIT   = 4;
    localparam int         CTL_MODE_HI  = 3;
    localparam int         CTL_MODE_LO  = 2;
    localparam int         CTL_IFG_BIT  = 1;
    localparam int         CTL_PRE_BIT  = 0;
    localparam logic [6:0] CTRL_RST     = 7'h00;
    localparam logic [6:0] CODE_RST     = 7'h00;

    // ==========================================================
    // Frame classes.
    localparam logic [1:0] CLS_ALL   = 2'h0;
    localparam logic [1:0] CLS_FLOOD = 2'h1;
    localparam logic [1:0] CLS_MULTI = 2'h2;
    localparam logic [1:0] CLS_BCAST = 2'h3;

    // ==========================================================
    // Accounting: one interval of 125 ms makes every rate a whole number.
    localparam int unsigned  CLK_PERIOD_NS = 50;
    localparam int unsigned  INTERVAL_NS   = 125000000;
    localparam int unsigned  INTERVAL_CYC  = INTERVAL_NS / CLK_PERIOD_NS;
    localparam logic [31:0]  IFG_BYTES     = 32'h0000000C;
    localparam logic [31:0]  PRE_BYTES     = 32'h00000008;
    // Bytes per interval at 1 Mbps, packets per interval at 1.92k pps.
    localparam logic [31:0]  BIT_UNIT      = 32'h00003D09;
    localparam logic [31:0]  PKT_UNIT      = 32'h000000F0;
    // Low codes: 64 kbps in bytes, 64 pps and 128 pps in packets.
    localparam logic [31:0]  BIT_LOW       = 32'h000003E8;
    localparam logic [31:0]  PKT_LOW_FIRST = 32'h00000008;
    localparam logic [31:0]  PKT_LOW_STEP  = 32'h00000010;
    localparam logic [6:0]   CODE_LINE     = 7'h00;
    localparam logic [6:0]   CODE_MID_LO   = 7'h0A;
    localparam logic [6:0]   CODE_MID_HI   = 7'h64;
    localparam logic [6:0]   CODE_LOW_HI   = 7'h73;

    typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} prl_speed_e;

    typedef struct packed {
        logic [13:0] len;
        logic [2:0]  prio;
        logic        bcast;
        logic        mcast;
        logic        flood;
    } prl_frame_s;

endpackage

// >>> verilog/prl_limiter.sv
// Ingress rate policing for one switch port.
// Assumes frame descriptors and link speed come from the port MAC on CLK_I.
`timescale 1ns/10ps

// Behaviour
// - Control bit 6 set limits all port traffic with one code, clear limits only priority-0 traffic.
// - Control bit 5 set measures packets per interval, clear measures bits.
// - With bit 4 and port flow control both on, an exceeded rate raises flow control.
// - Bits 3:2 pick the counted class: all, flood+multi+bcast, multi+bcast, bcast.
// - The gap bit adds twelve bytes per counted frame.
// - The preamble bit adds eight bytes per counted frame.
// - The gap and preamble bits are ignored in packet mode.
// - The priority-0 register holds a 7-bit code, reset zero, bit 7 reads zero.
// - A new priority-0 code takes effect only when the priority-7 register is written.
// - Codes 1 to 10 give code times 1 Mbps, or code times the packet unit (ten times that at 1000M).
// - Codes 11 to 100 hold 10 Mbps at 10M and scale per code at 100M and 1000M.
// - Codes 101 to 115 give the fixed low rates with speed-dependent scaling.
module prl_limiter
    import prl_pkg::*;
#(
    parameter int unsigned INTERVAL_CYCLES = INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        SRST_I,
    // Register port
    input  wire logic [11:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    // Port MAC side
    input  wire logic        FRM_VALID_I,
    input  prl_frame_s       FRM_I,
    input  prl_speed_e       LINK_SPEED_I,
    input  wire logic        PORT_FC_EN_I,
    output logic             FRM_DONE_O,
    output logic             FRM_DROP_O,
    output logic             FLOW_CTRL_O
);

    // ==========================================================
    // Rate code to allowance per interval.
    function automatic logic [31:0] rate_allow(input logic [6:0] code,
                                               input prl_speed_e spd,
                                               input logic pkt);
        logic [31:0] c;
        logic [31:0] n;
        logic [31:0] unit;
        logic [31:0] line;
        logic [31:0] scale;
        logic [31:0] low;
        c     = {25'h0000000, code};
        n     = c - {25'h0000000, CODE_MID_HI};
        unit  = pkt ? PKT_UNIT : BIT_UNIT;
        line  = (spd == SPD_1000) ? 32'h000003E8 :
                (spd == SPD_100)  ? 32'h00000064 : 32'h0000000A;
        scale = (spd == SPD_1000 && (pkt || code > CODE_MID_LO)) ?
                32'h0000000A : 32'h00000001;
        if (pkt) begin
            low = (n == 32'h00000001) ? PKT_LOW_FIRST : PKT_LOW_STEP * (n - 32'h00000001);
            if (spd == SPD_1000) begin
                low = low * 32'h0000000A;
            end
        end else begin
            low = BIT_LOW * n;
            if (spd == SPD_1000 || (spd == SPD_100 && n <= 32'h00000003)) begin
                low = low * 32'h0000000A;
            end
        end
        if (code == CODE_LINE || code > CODE_LOW_HI) begin
            rate_allow = unit * line;
        end else if (code <= CODE_MID_LO) begin
            rate_allow = c * unit * scale;
        end else if (code <= CODE_MID_HI) begin
            // Packet limit at 10M is undefined here; it falls back to line rate.
            rate_allow = (spd == SPD_10) ? unit * 32'h0000000A : c * unit * scale;
        end else begin
            rate_allow = low;
        end
    endfunction

    function automatic logic class_hit(input logic [1:0] mode, input prl_frame_s f);
        unique case (mode)
            CLS_ALL:   class_hit = 1'b1;
            CLS_FLOOD: class_hit = f.bcast | f.mcast | f.flood;
            CLS_MULTI: class_hit = f.bcast | f.mcast;
            CLS_BCAST: class_hit = f.bcast;
        endcase
    endfunction

    // ==========================================================
    // Registers.
    logic [6:0]  ctrl_r;
    logic [6:0]  pend_code_r;
    logic [6:0]  act_code_r;
    logic [31:0] allow_r;
    logic [31:0] used_r;
    logic [31:0] tick_cnt_r;
    logic        wr_ctrl;
    logic        wr_p0;
    logic        wr_p7;

    assign wr_ctrl = WR_I && ADDR_I == OFS_CTRL;
    assign wr_p0   = WR_I && ADDR_I == OFS_PRIO0;
    assign wr_p7   = WR_I && ADDR_I == OFS_PRIO7;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= WDATA_I[6:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pend_code_r <= CODE_RST;
        end else if (wr_p0) begin
            pend_code_r <= WDATA_I[6:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            act_code_r <= CODE_RST;
        end else if (wr_p7) begin
            act_code_r <= pend_code_r;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            unique case (ADDR_I)
                OFS_CTRL:   RDATA_O <= {1'b0, ctrl_r};
                OFS_PRIO0:  RDATA_O <= {1'b0, pend_code_r};
                OFS_STATUS: RDATA_O <= {FLOW_CTRL_O, act_code_r};
                default:    RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // ==========================================================
    // Accounting.
    logic        pkt_mode;
    logic        fc_eff;
    logic        counted;
    logic        over;
    logic        drop;
    logic        tick;
    logic [31:0] cost;

    assign pkt_mode = ctrl_r[CTL_PKT_BIT];
    assign fc_eff   = ctrl_r[CTL_FC_BIT] & PORT_FC_EN_I;
    assign counted  = FRM_VALID_I
                    && class_hit(ctrl_r[CTL_MODE_HI:CTL_MODE_LO], FRM_I)
                    && (ctrl_r[CTL_PORT_BIT] || FRM_I.prio == 3'h0);
    assign tick     = tick_cnt_r >= INTERVAL_CYCLES - 1;
    assign over     = (used_r + cost) > allow_r;
    assign drop     = counted && over && !fc_eff;

    always_comb begin
        if (pkt_mode) begin
            cost = 32'h00000001;
        end else begin
            cost = {18'h00000, FRM_I.len}
                 + (ctrl_r[CTL_IFG_BIT] ? IFG_BYTES : 32'h00000000)
                 + (ctrl_r[CTL_PRE_BIT] ? PRE_BYTES : 32'h00000000);
        end
    end

    // The allowance is refreshed every cycle, so a speed change acts one cycle later.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            allow_r <= 32'h00000000;
        end else begin
            allow_r <= rate_allow(act_code_r, LINK_SPEED_I, pkt_mode);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I || tick) begin
            tick_cnt_r <= 32'h00000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
        end
    end

    // A frame accepted on the boundary cycle opens the new interval.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            used_r <= 32'h00000000;
        end else if (tick) begin
            used_r <= (counted && !drop) ? cost : 32'h00000000;
        end else if (counted && !drop) begin
            used_r <= used_r + cost;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I || !fc_eff) begin
            FLOW_CTRL_O <= 1'b0;
        end else if (counted && over) begin
            FLOW_CTRL_O <= 1'b1;
        end else if (tick) begin
            FLOW_CTRL_O <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            FRM_DONE_O <= 1'b0;
            FRM_DROP_O <= 1'b0;
        end else begin
            FRM_DONE_O <= FRM_VALID_I;
            FRM_DROP_O <= drop;
        end
    end

    // ==========================================================
    // Checks.
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    a_commit_on_p7: assert property (wr_p7 |=> act_code_r == $past(pend_code_r))
        else $error("Priority-7 write did not commit the pending code.");
    a_pend_no_apply: assert property (wr_p0 |=> act_code_r == $past(act_code_r))
        else $error("Priority-0 write changed the active code early.");
    a_p0_reserved: assert property (RD_I && ADDR_I == OFS_PRIO0 |=> RDATA_O[7] == 1'b0)
        else $error("Reserved bit of priority-0 register read as one.");
    a_fc_gated: assert property (!fc_eff |=> !FLOW_CTRL_O)
        else $error("Flow control raised while not in effect.");
    a_fc_raise: assert property (fc_eff && counted && over |=> FLOW_CTRL_O)
        else $error("Flow control not raised on exceeded rate.");
    a_drop_cause: assert property (FRM_DROP_O |-> $past(over) && !$past(fc_eff))
        else $error("Frame dropped without cause.");
    a_p0_readback: assert property (RD_I && ADDR_I == OFS_PRIO0
                                    |=> RDATA_O == {1'b0, $past(pend_code_r)})
        else $error("Priority-0 register did not read back the pending code.");
    a_bcast_only: assert property (FRM_VALID_I && ctrl_r[3:2] == CLS_BCAST
                                   && !FRM_I.bcast |=> FRM_DONE_O && !FRM_DROP_O)
        else $error("Non-broadcast frame limited in broadcast-only mode.");
    a_prio_split: assert property (FRM_VALID_I && !ctrl_r[CTL_PORT_BIT]
                                   && FRM_I.prio != 3'h0 |-> !counted)
        else $error("Non-zero priority counted in priority mode.");
    a_pkt_cost: assert property (pkt_mode && FRM_VALID_I |-> cost == 32'h00000001)
        else $error("Packet mode charged more than one unit.");

    // Charging, limiting and status readback.
    a_ifg_cost: assert property (FRM_VALID_I && !pkt_mode && ctrl_r[1:0] == 2'h2
                                 |-> cost == {18'h00000, FRM_I.len} + 32'h0000000C)
        else $error("Gap bytes not charged.");
    a_pre_cost: assert property (FRM_VALID_I && !pkt_mode && ctrl_r[1:0] == 2'h1
                                 |-> cost == {18'h00000, FRM_I.len} + 32'h00000008)
        else $error("Preamble bytes not charged.");
    a_no_extra: assert property (FRM_VALID_I && !pkt_mode && ctrl_r[1:0] == 2'h0
                                 |-> cost == {18'h00000, FRM_I.len})
        else $error("Gap or preamble bytes charged while off.");
    a_port_count: assert property (FRM_VALID_I && ctrl_r[CTL_PORT_BIT]
                                   && ctrl_r[3:2] == CLS_ALL |-> counted)
        else $error("Frame not counted in port mode.");
    a_uncounted_pass: assert property (FRM_VALID_I && !counted
                                       |=> FRM_DONE_O && !FRM_DROP_O)
        else $error("Uncounted frame was limited.");
    a_over_drop: assert property (counted && over && !fc_eff |=> FRM_DROP_O)
        else $error("Frame over the limit was forwarded.");
    a_fc_no_drop: assert property (fc_eff |=> !FRM_DROP_O)
        else $error("Frame dropped while flow control is in effect.");
    a_status_read: assert property (RD_I && ADDR_I == OFS_STATUS
                                    |=> RDATA_O == {$past(FLOW_CTRL_O), $past(act_code_r)})
        else $error("Status read does not show the active code.");

    // ==========================================================
    // Rate selection. The allowance trails its inputs by one cycle, so each
    // check waits for two steady cycles before it looks.
    a_line_rate: assert property ((act_code_r == 7'h00 && LINK_SPEED_I == SPD_1000
                                   && !pkt_mode) [*2] |-> allow_r == 32'h00EE6B28)
        else $error("Code zero at 1000M is not line rate.");
    a_pkt_code_one: assert property ((act_code_r == 7'h01 && LINK_SPEED_I == SPD_10
                                      && pkt_mode) [*2] |-> allow_r == 32'h000000F0)
        else $error("Code one in packet mode at 10M is wrong.");
    a_mid_gig: assert property ((act_code_r == 7'h0B && LINK_SPEED_I == SPD_1000
                                 && !pkt_mode) [*2] |-> allow_r == 32'h001A39DE)
        else $error("Code eleven at 1000M is wrong.");
    a_speed_follow: assert property ((act_code_r == 7'h0B && LINK_SPEED_I == SPD_100
                                      && !pkt_mode) [*2] |-> allow_r == 32'h00029F63)
        else $error("Code eleven at 100M is wrong.");
    a_low_bit_rate: assert property ((act_code_r == 7'h65 && LINK_SPEED_I == SPD_10
                                      && !pkt_mode) [*2] |-> allow_r == 32'h000003E8)
        else $error("Lowest bit rate code at 10M is wrong.");

    c_drop: cover property (FRM_DROP_O);
    c_flow: cover property (FLOW_CTRL_O);
    c_commit: cover property (wr_p0 ##[1:8] wr_p7);
    c_fc_over: cover property (fc_eff && counted && over);
    c_low_drop: cover property (act_code_r > CODE_MID_HI && FRM_DROP_O);

endmodule

// >>> testbench/prl_mac_model.sv
// Port MAC model: hands received frame descriptors to the limiter.
// Assumes the limiter answers each descriptor exactly one cycle after taking it.
`timescale 1ns/10ps
module prl_mac_model
    import prl_pkg::*;
(
    // Clock
    input  wire logic clk_i,
    // Descriptor side
    output logic       frm_valid_o,
    output prl_frame_s frm_o,
    // Answer side
    input  wire logic frm_done_i,
    input  wire logic frm_drop_i
);
    initial begin
        frm_valid_o = 1'b0;
        frm_o       = '0;
    end

    // ==========================================================
    // Frame delivery
    // A released descriptor bus shows the inverse of the last value, so a
    // limiter that samples it outside the strobe cannot pass by luck.
    task automatic send(input prl_frame_s f, output logic done, output logic drop);
        @(posedge clk_i);
        frm_valid_o <= 1'b1;
        frm_o       <= f;
        @(posedge clk_i);
        frm_valid_o <= 1'b0;
        frm_o       <= ~f;
        @(posedge clk_i);
        done = frm_done_i;
        drop = frm_drop_i;
    endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench of the port ingress rate limiter.
// Assumes the MAC model file and the package are compiled first.
`timescale 1ns/10ps
module tb;
    import prl_pkg::*;
    typedef struct {
        logic [7:0] ctrl; logic [6:0] code; prl_speed_e spd; logic [2:0] cls;
        logic [2:0] prio; logic [13:0] len; logic [7:0] n; logic fcen; logic commit;
        logic [7:0] pass; logic fc;
    } prl_row_s;

    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fvalid, fc_en = 1'b0;
    logic done, drop, flow, done_s, drop_s;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00, rdata, v, passed;
    prl_frame_s frm, f;
    prl_speed_e spd = SPD_10;
    int error_cnt = 0, n_compared = 0;

    // Frames are {bcast, mcast, flood} in cls; every row ends inside one interval.
    prl_row_s rows [24] = '{
        '{8'h40, 7'h01, SPD_10,   3'h0, 3'h0, 14'h1388, 8'h04, 1'b0, 1'b1, 8'h03, 1'b0},
        '{8'h42, 7'h01, SPD_10,   3'h0, 3'h0, 14'h1455, 8'h04, 1'b0, 1'b1, 8'h02, 1'b0},
        '{8'h41, 7'h01, SPD_10,   3'h0, 3'h0, 14'h1451, 8'h04, 1'b0, 1'b1, 8'h02, 1'b0},
        '{8'h61, 7'h65, SPD_10,   3'h0, 3'h0, 14'h0064, 8'h0A, 1'b0, 1'b1, 8'h08, 1'b0},
        '{8'h60, 7'h65, SPD_1000, 3'h0, 3'h0, 14'h0064, 8'h52, 1'b0, 1'b1, 8'h50, 1'b0},
        '{8'h40, 7'h0B, SPD_10,   3'h0, 3'h0, 14'h3E80, 8'h0B, 1'b0, 1'b1, 8'h09, 1'b0},
        '{8'h40, 7'h0B, SPD_100,  3'h0, 3'h0, 14'h3E80, 8'h0B, 1'b0, 1'b1, 8'h0A, 1'b0},
        '{8'h40, 7'h00, SPD_10,   3'h0, 3'h0, 14'h3E80, 8'h0B, 1'b0, 1'b1, 8'h09, 1'b0},
        '{8'h44, 7'h01, SPD_10,   3'h1, 3'h0, 14'h2710, 8'h03, 1'b0, 1'b1, 8'h01, 1'b0},
        '{8'h48, 7'h01, SPD_10,   3'h1, 3'h0, 14'h2710, 8'h03, 1'b0, 1'b1, 8'h03, 1'b0},
        '{8'h4C, 7'h01, SPD_10,   3'h2, 3'h0, 14'h2710, 8'h03, 1'b0, 1'b1, 8'h03, 1'b0},
        '{8'h48, 7'h01, SPD_10,   3'h2, 3'h0, 14'h2710, 8'h03, 1'b0, 1'b1, 8'h01, 1'b0},
        '{8'h00, 7'h01, SPD_10,   3'h0, 3'h3, 14'h2710, 8'h03, 1'b0, 1'b1, 8'h03, 1'b0},
        '{8'h00, 7'h01, SPD_10,   3'h0, 3'h0, 14'h2710, 8'h03, 1'b0, 1'b1, 8'h01, 1'b0},
        '{8'h50, 7'h01, SPD_10,   3'h0, 3'h0, 14'h2710, 8'h03, 1'b1, 1'b1, 8'h03, 1'b1},
        '{8'h50, 7'h01, SPD_10,   3'h0, 3'h0, 14'h2710, 8'h03, 1'b0, 1'b1, 8'h01, 1'b0},
        '{8'h40, 7'h01, SPD_10,   3'h0, 3'h0, 14'h2710, 8'h03, 1'b1, 1'b1, 8'h01, 1'b0},
        '{8'h40, 7'h01, SPD_10,   3'h0, 3'h0, 14'h2710, 8'h03, 1'b0, 1'b0, 8'h03, 1'b0},
        '{8'h40, 7'h65, SPD_10,   3'h0, 3'h0, 14'h01F4, 8'h03, 1'b0, 1'b1, 8'h02, 1'b0},
        '{8'h40, 7'h68, SPD_100,  3'h0, 3'h0, 14'h07D0, 8'h03, 1'b0, 1'b1, 8'h02, 1'b0},
        '{8'h40, 7'h65, SPD_1000, 3'h0, 3'h0, 14'h0FA0, 8'h03, 1'b0, 1'b1, 8'h02, 1'b0},
        '{8'h60, 7'h01, SPD_10,   3'h0, 3'h0, 14'h0040, 8'hF2, 1'b0, 1'b1, 8'hF0, 1'b0},
        '{8'h40, 7'h0B, SPD_1000, 3'h0, 3'h0, 14'h3E80, 8'h6C, 1'b0, 1'b1, 8'h6B, 1'b0},
        '{8'h40, 7'h00, SPD_1000, 3'h0, 3'h0, 14'h3E80, 8'h03, 1'b0, 1'b1, 8'h03, 1'b0}
    };

    always #25 clk = ~clk;

    prl_limiter #(.INTERVAL_CYCLES(5000)) DUT (
        .CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .FRM_VALID_I(fvalid), .FRM_I(frm), .LINK_SPEED_I(spd),
        .PORT_FC_EN_I(fc_en), .FRM_DONE_O(done), .FRM_DROP_O(drop), .FLOW_CTRL_O(flow)
    );
    prl_mac_model mac (.clk_i(clk), .frm_valid_o(fvalid), .frm_o(frm),
                       .frm_done_i(done), .frm_drop_i(drop));

    // ==========================================================
    // Bus, reset and comparison helpers
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            do_reset();
            spd   <= rows[i].spd;
            fc_en <= rows[i].fcen;
            wr_reg(OFS_CTRL, rows[i].ctrl);
            wr_reg(OFS_PRIO0, {1'b0, rows[i].code});
            if (rows[i].commit) begin
                wr_reg(OFS_PRIO7, 8'h00);
            end
            passed = 8'h00;
            for (int k = 0; k < rows[i].n; k++) begin
                f.len  = rows[i].len;
                f.prio = rows[i].prio;
                {f.bcast, f.mcast, f.flood} = rows[i].cls;
                mac.send(f, done_s, drop_s);
                chk({7'h00, done_s}, 8'h01, "frame answer");
                if (done_s === 1'b1 && drop_s === 1'b0) passed++;
            end
            chk(passed, rows[i].pass, "frames forwarded");
            chk({7'h00, flow}, {7'h00, rows[i].fc}, "flow control");
            $display("Row %0d done", i);
        end
        // A link speed change inside an interval must move the limit at once.
        do_reset();
        spd <= SPD_10;
        wr_reg(OFS_CTRL, 8'h40);
        wr_reg(OFS_PRIO0, 8'h0B);
        wr_reg(OFS_PRIO7, 8'h00);
        f = '{len: 14'h3E80, prio: 3'h0, bcast: 1'b0, mcast: 1'b0, flood: 1'b0};
        passed = 8'h00;
        for (int k = 0; k < 11; k++) begin
            if (k == 10) begin
                spd <= SPD_100;
            end
            mac.send(f, done_s, drop_s);
            if (done_s === 1'b1 && drop_s === 1'b0) begin
                passed++;
            end
        end
        chk(passed, 8'h0A, "speed change");
        $display("Speed change test done");
        do_reset();
        rd_reg(OFS_CTRL, v);
        chk(v, 8'h00, "control reset");
        rd_reg(OFS_PRIO0, v);
        chk(v, 8'h00, "code reset");
        wr_reg(OFS_PRIO0, 8'hFF);
        rd_reg(OFS_PRIO0, v);
        chk(v, 8'h7F, "code reserved bit");
        rd_reg(OFS_STATUS, v);
        chk(v, 8'h00, "code still pending");
        wr_reg(OFS_PRIO7, 8'h12);
        rd_reg(OFS_STATUS, v);
        chk(v, 8'h7F, "code applied");
        rd_reg(OFS_PRIO7, v);
        chk(v, 8'h00, "commit reads zero");
        wr_reg(OFS_CTRL, 8'hFF);
        rd_reg(OFS_CTRL, v);
        chk(v, 8'h7F, "control reserved bit");
        rd_reg(12'h400, v);
        chk(v, 8'h00, "unmapped read");
        $display("Register test done");
        results();
    end

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("Error at %0t: run did not finish", $time);
        results();
    end
endmodule
